// ### logic/moc_cfg.svh
// constants for the mask option configuration block
`ifndef MOC_CFG_SVH
`define MOC_CFG_SVH

// cpu bus location of the option straps register
`define MOC_OPT_ADDR      16'h001f
`define MOC_ADDR_W        16

// bit positions inside the option straps register
`define MOC_BIT_LOCK      6
`define MOC_BIT_LV_RST    5
`define MOC_BIT_LV_PWR    4
`define MOC_BIT_SHORT     3
`define MOC_BIT_LONG_WD   2
`define MOC_BIT_STOP_EN   1
`define MOC_BIT_WD_OFF    0

// counter width and wake delays in reference clock cycles
`define MOC_CNT_W         18
`define MOC_WAKE_SHORT    18'h00020
`define MOC_WAKE_LONG     18'h01000

// fixed values on the bus and at reset
`define MOC_RDATA_RST     8'h00
`define MOC_UNUSED_TOP    1'h0

`endif

// ### logic/moc_pkg.sv
// types shared by the mask option configuration block
package moc_pkg;

  // stop instruction sequencing
  typedef enum logic [1:0] {
    MOC_RUN,
    MOC_STOPPED,
    MOC_WAKING
  } moc_stop_e;

  typedef logic [17:0] moc_count_t;

endpackage

// ### logic/moc_tick_counter.sv
// reference tick counter that pulses once per completed period
`timescale 1ns/1ps
`default_nettype none

module moc_tick_counter #(
  parameter int W = 18
) (
  // clock and control
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // counting
  input  wire logic         run,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  // result
  output var  logic         done_ff
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic         nxt_done;

  // count ticks; stopping or clearing restarts the period from zero
  always_comb begin
    nxt_count = count_ff;
    nxt_done  = 1'b0;
    if (!run || clear) begin
      nxt_count = '0;
    end else if (tick) begin
      if (count_ff == limit - W'(1)) begin
        nxt_count = '0;
        nxt_done  = 1'b1;
      end else begin
        nxt_count = count_ff + W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else if (ce) begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

endmodule

`default_nettype wire

// ### logic/moc_option_straps.sv
// option straps register and the chip controls it steers
`timescale 1ns/1ps
`default_nettype none
`include "moc_cfg.svh"

module moc_option_straps #(
  // hard-wired mask choices, fixed when the rom code is chosen
  parameter logic [6:0]          OPTION_STRAPS = 7'h00,
  parameter moc_pkg::moc_count_t WDOG_SHORT    = 18'd8176,
  parameter moc_pkg::moc_count_t WDOG_LONG     = 18'd262128
) (
  // clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   ce,
  // internal cpu bus
  input  wire logic [`MOC_ADDR_W-1:0] bus_addr,
  input  wire logic                   bus_rd,
  input  wire logic                   bus_wr,
  output var  logic [7:0]             bus_rdata_ff,
  output var  logic                   bus_hit_ff,
  // crystal_ref_clock cycle marker
  input  wire logic                   ref_tick,
  // rom protection
  input  wire logic                   ext_rom_rd_req,
  output var  logic                   ext_rom_rd_grant_ff,
  output var  logic                   rom_read_lock_ff,
  // low_voltage_monitor
  input  wire logic                   lowv_reset_req,
  output var  logic                   lowv_power_en_ff,
  output var  logic                   lowv_reset_ff,
  // stop instruction handling
  input  wire logic                   stop_req,
  input  wire logic                   wake_req,
  output var  logic                   stop_mode_ff,
  output var  logic                   wake_done_ff,
  output var  logic                   illegal_opcode_ff,
  // watchdog_unit
  input  wire logic                   wdog_service,
  output var  logic                   wdog_enable_ff,
  output var  logic                   wdog_timeout_ff
);

  // individual straps, constants so no reset can reach them
  localparam logic LOCK    = OPTION_STRAPS[`MOC_BIT_LOCK];
  localparam logic LV_RST  = OPTION_STRAPS[`MOC_BIT_LV_RST];
  localparam logic LV_PWR  = OPTION_STRAPS[`MOC_BIT_LV_PWR];
  localparam logic SHORT   = OPTION_STRAPS[`MOC_BIT_SHORT];
  localparam logic LONG_WD = OPTION_STRAPS[`MOC_BIT_LONG_WD];
  localparam logic STOP_EN = OPTION_STRAPS[`MOC_BIT_STOP_EN];
  localparam logic WD_OFF  = OPTION_STRAPS[`MOC_BIT_WD_OFF];

  // picks one of two cycle counts by a strap
  function automatic moc_pkg::moc_count_t pick_count(
    input logic               sel,
    input moc_pkg::moc_count_t when_set,
    input moc_pkg::moc_count_t when_clr
  );
    pick_count = sel ? when_set : when_clr;
  endfunction

  // ---------------- bus read path ----------------
  logic [7:0] nxt_rdata;
  logic       nxt_hit;
  logic       rd_hit;

  // a write cycle loads nothing but a cleared bus_hit_ff; the strap values have no
  // storage a write could reach, so the address is read-only
  assign rd_hit = bus_rd && !bus_wr && (bus_addr == `MOC_OPT_ADDR);

  // whole register in one access, unused top bit zero
  always_comb begin
    nxt_hit   = rd_hit;
    nxt_rdata = bus_rdata_ff;
    if (rd_hit) begin
      nxt_rdata = {`MOC_UNUSED_TOP, OPTION_STRAPS};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bus_rdata_ff <= `MOC_RDATA_RST;
      bus_hit_ff   <= 1'b0;
    end else if (ce) begin
      bus_rdata_ff <= nxt_rdata;
      bus_hit_ff   <= nxt_hit;
    end
  end

  // ---------------- static controls ----------------
  logic nxt_grant;
  logic nxt_lock;
  logic nxt_lv_pwr;
  logic nxt_lv_rst;
  logic nxt_wd_en;

  // registered so every control leaves the block from a flop
  always_comb begin
    nxt_lock   = LOCK;
    nxt_grant  = ext_rom_rd_req && !LOCK;
    nxt_lv_pwr = !LV_PWR;
    nxt_lv_rst = lowv_reset_req && !LV_RST;
    nxt_wd_en  = !WD_OFF;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rom_read_lock_ff    <= 1'b1;
      ext_rom_rd_grant_ff <= 1'b0;
      lowv_power_en_ff    <= 1'b0;
      lowv_reset_ff       <= 1'b0;
      wdog_enable_ff      <= 1'b0;
    end else if (ce) begin
      rom_read_lock_ff    <= nxt_lock;
      ext_rom_rd_grant_ff <= nxt_grant;
      lowv_power_en_ff    <= nxt_lv_pwr;
      lowv_reset_ff       <= nxt_lv_rst;
      wdog_enable_ff      <= nxt_wd_en;
    end
  end

  // ---------------- stop and wake sequencing ----------------
  moc_pkg::moc_stop_e state_ff;
  moc_pkg::moc_stop_e nxt_state;
  logic               nxt_stop_mode;
  logic               nxt_wake_done;
  logic               nxt_illegal;
  logic               wake_cnt_done;
  moc_pkg::moc_count_t wake_limit;

  // short delay only suits a fast-starting reference source
  assign wake_limit = pick_count(SHORT, `MOC_WAKE_SHORT,
                                 `MOC_WAKE_LONG);

  always_comb begin
    nxt_state     = state_ff;
    nxt_stop_mode = stop_mode_ff;
    nxt_wake_done = 1'b0;
    nxt_illegal   = 1'b0;
    case (state_ff)
      moc_pkg::MOC_RUN: begin
        if (stop_req) begin
          if (STOP_EN) begin
            nxt_state     = moc_pkg::MOC_STOPPED;
            nxt_stop_mode = 1'b1;
          end else begin
            nxt_illegal = 1'b1;
          end
        end
      end
      moc_pkg::MOC_STOPPED: begin
        if (wake_req) begin
          nxt_state = moc_pkg::MOC_WAKING;
        end
      end
      moc_pkg::MOC_WAKING: begin
        // leave stop only once the full delay has elapsed
        if (wake_cnt_done) begin
          nxt_state     = moc_pkg::MOC_RUN;
          nxt_stop_mode = 1'b0;
          nxt_wake_done = 1'b1;
        end
      end
      default: begin
        nxt_state     = moc_pkg::MOC_RUN;
        nxt_stop_mode = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff          <= moc_pkg::MOC_RUN;
      stop_mode_ff      <= 1'b0;
      wake_done_ff      <= 1'b0;
      illegal_opcode_ff <= 1'b0;
    end else if (ce) begin
      state_ff          <= nxt_state;
      stop_mode_ff      <= nxt_stop_mode;
      wake_done_ff      <= nxt_wake_done;
      illegal_opcode_ff <= nxt_illegal;
    end
  end

  // wake delay counter runs only while waking
  moc_tick_counter #(
    .W       (`MOC_CNT_W)
  ) u_wake_cnt (
    .core_clk(core_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .run     (state_ff == moc_pkg::MOC_WAKING),
    .clear   (1'b0),
    .tick    (ref_tick),
    .limit   (wake_limit),
    .done_ff (wake_cnt_done)
  );

  // ---------------- watchdog period ----------------
  moc_pkg::moc_count_t wdog_limit;

  assign wdog_limit = pick_count(LONG_WD, WDOG_LONG, WDOG_SHORT);

  // held at zero when the watchdog is strapped off
  moc_tick_counter #(
    .W       (`MOC_CNT_W)
  ) u_wdog_cnt (
    .core_clk(core_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .run     (!WD_OFF),
    .clear   (wdog_service),
    .tick    (ref_tick),
    .limit   (wdog_limit),
    .done_ff (wdog_timeout_ff)
  );

endmodule

`default_nettype wire

// ### bench/moc_option_straps_properties.sv
// port assertions for the option straps register block
`timescale 1ns/1ps
`default_nettype none
module moc_option_checks #(
  parameter logic [6:0] OPTION_STRAPS = 7'h00
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        ce,
  // cpu bus
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [7:0]  bus_rdata_ff,
  input wire logic        bus_hit_ff,
  // chip controls
  input wire logic        ext_rom_rd_req,
  input wire logic        ext_rom_rd_grant_ff,
  input wire logic        rom_read_lock_ff,
  input wire logic        lowv_reset_req,
  input wire logic        lowv_power_en_ff,
  input wire logic        lowv_reset_ff,
  input wire logic        stop_req,
  input wire logic        stop_mode_ff,
  input wire logic        illegal_opcode_ff,
  input wire logic        wdog_enable_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // a taken read answers one edge later with the fixed byte
  property p_read;
    ce && bus_rd && !bus_wr && bus_addr == 16'h001f
      |=> bus_hit_ff && bus_rdata_ff == {1'b0, OPTION_STRAPS};
  endproperty
  a_read: assert property (p_read) else $error("bad read");
  property p_wr;
    ce && bus_wr |=> !bus_hit_ff && $stable(bus_rdata_ff);
  endproperty
  a_wr: assert property (p_wr) else $error("write acted");
  // static controls settle one edge after reset release
  property p_lock;
    $past(reset_n) |-> rom_read_lock_ff == OPTION_STRAPS[6];
  endproperty
  a_lock: assert property (p_lock) else $error("bad lock");
  property p_grant;
    ce && ext_rom_rd_req |=> ext_rom_rd_grant_ff == !OPTION_STRAPS[6];
  endproperty
  a_grant: assert property (p_grant) else $error("bad grant");
  property p_lvpwr;
    $past(reset_n) |-> lowv_power_en_ff == !OPTION_STRAPS[4];
  endproperty
  a_lvpwr: assert property (p_lvpwr) else $error("bad power");
  property p_lvrst;
    ce && lowv_reset_req |=> lowv_reset_ff == !OPTION_STRAPS[5];
  endproperty
  a_lvrst: assert property (p_lvrst) else $error("bad reset");
  property p_stop;
    ce && stop_req && !stop_mode_ff
      |=> stop_mode_ff == OPTION_STRAPS[1]
          && illegal_opcode_ff != OPTION_STRAPS[1];
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop");
  property p_wden;
    $past(reset_n) |-> wdog_enable_ff == !OPTION_STRAPS[0];
  endproperty
  a_wden: assert property (p_wden) else $error("bad wdog");
endmodule
`default_nettype wire

// ### bench/tb_mask_option_config.sv
// self-checking bench for the option straps register block
`timescale 1ns/1ps
`default_nettype none
module tb_mask_option_config;
  localparam logic [6:0] STRAPS = 7'h4a; // lock, short wake, stop allowed
  localparam logic [7:0] RD_EXP = {1'b0, STRAPS};
  localparam int         WAKE_N = 32; // short wake delay in ref ticks
  localparam int         WD_N   = 20; // shrunk watchdog period in ticks
  logic        core_clk = 1'b0, reset_n = 1'b0, ref_tick = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_rd = 1'b0, bus_wr = 1'b0, ext_rom_rd_req = 1'b0;
  logic        lowv_reset_req = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
  logic        wdog_service = 1'b1;
  logic [7:0]  bus_rdata_ff;
  logic        bus_hit_ff, ext_rom_rd_grant_ff, rom_read_lock_ff;
  logic        lowv_power_en_ff, lowv_reset_ff, stop_mode_ff, wake_done_ff;
  logic        illegal_opcode_ff, wdog_enable_ff, wdog_timeout_ff;
  int          num_errors = 0, n_tests = 0, n;
  // small watchdog periods keep the run short
  moc_option_straps #(.OPTION_STRAPS(STRAPS), .WDOG_SHORT(18'(WD_N)),
    .WDOG_LONG(18'd40)) uut (.core_clk, .reset_n, .ce(1'b1), .bus_addr,
    .bus_rd, .bus_wr, .bus_rdata_ff, .bus_hit_ff, .ref_tick, .ext_rom_rd_req,
    .ext_rom_rd_grant_ff, .rom_read_lock_ff, .lowv_reset_req,
    .lowv_power_en_ff, .lowv_reset_ff, .stop_req, .wake_req, .stop_mode_ff,
    .wake_done_ff, .illegal_opcode_ff, .wdog_service, .wdog_enable_ff,
    .wdog_timeout_ff);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one bus cycle; answer read just after the following edge
  task automatic acc(input logic [15:0] a, input logic rd, input logic wr);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= rd;
    bus_wr <= wr;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    #1;
  endtask
  // bounded edge count until a pulse shows; sel 1 watches the timeout,
  // 0 the wake pulse; always steps once so a pulse still high from the
  // previous call is not counted again
  task automatic wait_for(input logic sel, input int lim);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while ((sel ? wdog_timeout_ff : wake_done_ff) !== 1'b1 && n < lim);
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(rom_read_lock_ff, 1);
    chk(lowv_power_en_ff, 1);
    chk(wdog_enable_ff, 1);
    acc(16'h001f, 1, 0);
    chk(bus_hit_ff, 1);
    chk(bus_rdata_ff, RD_EXP);
    acc(16'h001f, 0, 1);
    chk(bus_hit_ff, 0);
    acc(16'h001f, 1, 1);
    chk(bus_hit_ff, 0);
    acc(16'h0020, 1, 0);
    chk(bus_rdata_ff, RD_EXP);
    // second reset must not disturb the straps
    @(posedge core_clk) reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    acc(16'h001f, 1, 0);
    chk(bus_rdata_ff, RD_EXP);
    @(posedge core_clk) begin
      ext_rom_rd_req <= 1'b1;
      lowv_reset_req <= 1'b1;
    end
    repeat (2) @(posedge core_clk);
    #1;
    chk(ext_rom_rd_grant_ff, 0);
    chk(lowv_reset_ff, 1);
    @(posedge core_clk) stop_req <= 1'b1;
    @(posedge core_clk) stop_req <= 1'b0;
    #1;
    chk(stop_mode_ff, 1);
    chk(illegal_opcode_ff, 0);
    @(posedge core_clk) begin
      wake_req <= 1'b1;
      ref_tick <= 1'b1;
    end
    @(posedge core_clk) wake_req <= 1'b0;
    // wake_req taken one edge in, wake_done_ff registered one edge after the edge of tick N
    wait_for(1'b0, 60);
    chk(8'(n), 8'(WAKE_N + 1));
    chk(stop_mode_ff, 0);
    @(posedge core_clk) wdog_service <= 1'b0;
    repeat (2) begin
      wait_for(1'b1, 60);
      chk(8'(n), 8'(WD_N));
    end
    finish_test();
  end
  // hang guard, far beyond the roughly 120 cycles expected
  initial begin
    #20us;
    num_errors++;
    finish_test();
  end
endmodule
bind moc_option_straps moc_option_checks #(.OPTION_STRAPS(OPTION_STRAPS))
  u_chk (.core_clk, .reset_n, .ce, .bus_addr, .bus_rd, .bus_wr, .bus_rdata_ff,
  .bus_hit_ff, .ext_rom_rd_req, .ext_rom_rd_grant_ff, .rom_read_lock_ff,
  .lowv_reset_req, .lowv_power_en_ff, .lowv_reset_ff, .stop_req,
  .stop_mode_ff, .illegal_opcode_ff, .wdog_enable_ff);
`default_nettype wire
